/* hdl/dcd_dual_channel_dac_control.sv */
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/100ps
// Operation
// (RULE1) route bit: internal path on, channel-0 pin off
// (RULE2) channel-1 enable drives channel-1 pin
// (RULE3) channel-0 enable drives pin unless routed internally
// (RULE4) low power: converter off between conversions
// (RULE5) low power doubles each new conversion time
// (RULE6) master enable gates the whole converter
// (RULE7) channel field: ch0, ch1, dual, reserved
// (RULE8) ch1 event start needs updated ch1 data
// (RULE9) ch0 event start needs updated ch0 data
// (RULE10) reference field picks one of four sources
// (RULE11) align bit selects left or right data
// (RULE12) event field picks event channel zero-seven
// (RULE13) split bit: channel 1 uses next event
// (RULE14) per-channel empty flag in status register
// (RULE15) write while not empty replaces pending value
// (RULE16) empty flag is the DMA request
// (RULE17) eight-bit channel-0 gain trim, reset zero
// (RULE18) eight-bit channel-0 offset trim, reset zero
// (RULE19) software writes zero to reserved bits
// (RULE20) without event mode, start on new data
// (RULE21) right-adjusted: low byte plus four high
// (RULE22) left-adjusted high-only write gives eight bits
// (RULE23) data write clears flag, start sets it
module dcd_dual_channel_dac_control (
   input  wire logic                 hclk,
   input  wire logic                 hresetn,
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic      [31:0]          hrdata,
   output logic                      hreadyout,
   output logic                      hresp,
   input  wire logic [7:0]           event_in,
   output logic      [1:0]           dma_request,
   output dcd_pkg::dcd_analog_t      chan0_analog,
   output dcd_pkg::dcd_analog_t      chan1_analog,
   output dcd_pkg::dcd_trim_t        trim
);

   // bus address phase capture
   logic                 wr_pend_q;
   logic [4:0]           wr_idx_q;
   logic [31:0]          hrdata_q;

   // registers
   logic [7:0]           control_a_q;
   logic [7:0]           control_b_q;
   logic [7:0]           control_c_q;
   logic [7:0]           trigger_sel_q;
   logic [7:0]           gain_q;
   logic [7:0]           offset_q;
   logic [7:0]           temp_q;
   logic [1:0]           empty_q;

   // per-channel datapath
   logic [11:0]          pend_val_q   [2];
   logic [1:0]           pend_q;
   logic [11:0]          out_val_q    [2];
   logic [dcd_pkg::CNT_W-1:0] cnt_q   [2];
   dcd_pkg::dcd_state_t  state_q      [2];

   // decoded address phase
   wire                  addr_phase;
   wire  [4:0]           a_idx;
   wire                  a_in_range;
   assign addr_phase = hsel && hready && htrans[1] && (htrans == dcd_pkg::HTRANS_NONSEQ_BIT || htrans[0]);
   assign a_idx      = haddr[dcd_pkg::IDX_MSB:dcd_pkg::IDX_LSB];
   assign a_in_range = (haddr[dcd_pkg::ADDR_TOP:dcd_pkg::IDX_MSB+1] == '0);

   // data phase write strobes
   wire                  wr_a;
   wire                  wr_b;
   wire                  wr_c;
   wire                  wr_ts;
   wire                  wr_flags;
   wire                  wr_gain;
   wire                  wr_offset;
   wire  [1:0]           wr_low;
   wire  [1:0]           wr_high;
   wire  [7:0]           wbyte;
   assign wbyte     = hwdata[7:0];
   assign wr_a      = wr_pend_q && (wr_idx_q == dcd_pkg::IDX_CONTROL_A);
   assign wr_b      = wr_pend_q && (wr_idx_q == dcd_pkg::IDX_CONTROL_B);
   assign wr_c      = wr_pend_q && (wr_idx_q == dcd_pkg::IDX_CONTROL_C);
   assign wr_ts     = wr_pend_q && (wr_idx_q == dcd_pkg::IDX_TRIGGER_SEL);
   assign wr_flags  = wr_pend_q && (wr_idx_q == dcd_pkg::IDX_EMPTY_FLAGS);
   assign wr_gain   = wr_pend_q && (wr_idx_q == dcd_pkg::IDX_CH0_GAIN);
   assign wr_offset = wr_pend_q && (wr_idx_q == dcd_pkg::IDX_CH0_OFFSET);
   assign wr_low[0]  = wr_pend_q && (wr_idx_q == dcd_pkg::IDX_CH0_DATA_LOW);
   assign wr_low[1]  = wr_pend_q && (wr_idx_q == dcd_pkg::IDX_CH1_DATA_LOW);
   assign wr_high[0] = wr_pend_q && (wr_idx_q == dcd_pkg::IDX_CH0_DATA_HIGH);
   assign wr_high[1] = wr_pend_q && (wr_idx_q == dcd_pkg::IDX_CH1_DATA_HIGH);

   // control fields
   wire                  enable;
   wire                  low_power_select;
   wire                  chan0_pin_enable;
   wire                  chan1_pin_enable;
   wire                  internal_route_enable;
   wire  [1:0]           channel_count_select;
   wire  [1:0]           chan_event_start;
   wire  [1:0]           reference_select;
   wire                  align_high;
   wire  [2:0]           trigger_channel_select;
   wire                  trigger_split;
   assign enable                 = control_a_q[dcd_pkg::CA_ENABLE];
   assign low_power_select       = control_a_q[dcd_pkg::CA_LOW_POWER];
   assign chan0_pin_enable       = control_a_q[dcd_pkg::CA_CH0_PIN];
   assign chan1_pin_enable       = control_a_q[dcd_pkg::CA_CH1_PIN];
   assign internal_route_enable  = control_a_q[dcd_pkg::CA_INTERNAL_ROUTE];
   assign channel_count_select   = control_b_q[dcd_pkg::CB_CHANNEL_COUNT_SELECT_LSB +: 2];
   assign chan_event_start[0]    = control_b_q[dcd_pkg::CB_CH0_EVENT];
   assign chan_event_start[1]    = control_b_q[dcd_pkg::CB_CH1_EVENT];
   assign reference_select       = control_c_q[dcd_pkg::CC_REF_LSB +: 2];
   assign align_high             = control_c_q[dcd_pkg::CC_ALIGN_HIGH];
   assign trigger_channel_select = trigger_sel_q[2:0];
   assign trigger_split          = trigger_sel_q[dcd_pkg::TS_SPLIT];

   // channel activity from master enable and channel field
   wire  [1:0]           chan_active;
   assign chan_active[0] = enable && (channel_count_select == dcd_pkg::DCD_CHANNEL_COUNT_SELECT_SINGLE0 ||
                                      channel_count_select == dcd_pkg::DCD_CHANNEL_COUNT_SELECT_DUAL); // RULE6 RULE7
   assign chan_active[1] = enable && (channel_count_select == dcd_pkg::DCD_CHANNEL_COUNT_SELECT_ONE_CHANNEL_SECOND ||
                                      channel_count_select == dcd_pkg::DCD_CHANNEL_COUNT_SELECT_DUAL); // RULE6 RULE7

   // event channel choice; channel 1 may take the next one, wrapping at seven
   wire  [2:0]           ev_sel1;
   wire  [1:0]           chan_event;
   assign ev_sel1       = trigger_split ? (trigger_channel_select + 3'h1) : trigger_channel_select; // RULE13
   assign chan_event[0] = event_in[trigger_channel_select]; // RULE12
   assign chan_event[1] = event_in[ev_sel1]; // RULE12 RULE13

   // assembly of a committed value from the high byte and the temporary byte
   wire  [11:0]          commit_val;
   assign commit_val = align_high ? {wbyte, temp_q[7:4]}      // RULE11 RULE22
                                  : {wbyte[3:0], temp_q};     // RULE11 RULE21

   // start decision per channel
   wire  [1:0]           start;
   wire  [1:0]           idle;
   wire  [1:0]           done;
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_chan
         assign idle[ch]  = (state_q[ch] == dcd_pkg::DCD_ST_IDLE);
         assign done[ch]  = (state_q[ch] == dcd_pkg::DCD_ST_CONV) && (cnt_q[ch] == dcd_pkg::CNT_ONE);
         assign start[ch] = chan_active[ch] && pend_q[ch] && (idle[ch] || done[ch]) &&
                            (!chan_event_start[ch] || chan_event[ch]); // RULE8 RULE9 RULE20

         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               pend_val_q[ch] <= 12'h000;
            end else if (wr_high[ch]) begin
               pend_val_q[ch] <= commit_val; // RULE15
            end
         end

         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               pend_q[ch] <= 1'b0;
            end else if (wr_high[ch]) begin
               pend_q[ch] <= 1'b1; // RULE15
            end else if (start[ch]) begin
               pend_q[ch] <= 1'b0;
            end
         end

         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               out_val_q[ch] <= 12'h000;
            end else if (start[ch]) begin
               out_val_q[ch] <= pend_val_q[ch];
            end
         end

         // converter sequencer; a start while busy only follows the final count
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               state_q[ch] <= dcd_pkg::DCD_ST_IDLE;
               cnt_q[ch]   <= '0;
            end else if (!chan_active[ch]) begin
               state_q[ch] <= dcd_pkg::DCD_ST_IDLE; // RULE6
               cnt_q[ch]   <= '0;
            end else begin
               unique case (state_q[ch])
                  dcd_pkg::DCD_ST_IDLE: begin
                     if (start[ch]) begin
                        state_q[ch] <= dcd_pkg::DCD_ST_CONV;
                        cnt_q[ch]   <= low_power_select ? dcd_pkg::CONV_CNT_LP : dcd_pkg::CONV_CNT; // RULE5
                     end
                  end
                  dcd_pkg::DCD_ST_CONV: begin
                     if (start[ch]) begin
                        cnt_q[ch]   <= low_power_select ? dcd_pkg::CONV_CNT_LP : dcd_pkg::CONV_CNT; // RULE5
                     end else if (done[ch]) begin
                        state_q[ch] <= dcd_pkg::DCD_ST_IDLE;
                        cnt_q[ch]   <= '0;
                     end else begin
                        cnt_q[ch]   <= cnt_q[ch] - dcd_pkg::CNT_ONE;
                     end
                  end
                  default: begin
                     state_q[ch] <= dcd_pkg::DCD_ST_IDLE;
                     cnt_q[ch]   <= '0;
                  end
               endcase
            end
         end

         // empty flag: data write clears, start sets; software may write it too
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               empty_q[ch] <= 1'b0;
            end else if (wr_high[ch]) begin
               empty_q[ch] <= 1'b0; // RULE23
            end else if (start[ch]) begin
               empty_q[ch] <= 1'b1; // RULE14 RULE23
            end else if (wr_flags) begin
               empty_q[ch] <= wbyte[ch];
            end
         end
      end
   endgenerate

   // bus address phase registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_idx_q  <= 5'h00;
      end else begin
         wr_pend_q <= addr_phase && hwrite && a_in_range;
         wr_idx_q  <= a_idx;
      end
   end

   // register writes mask reserved bits so they always read zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         control_a_q <= dcd_pkg::RESET_BYTE;
         control_b_q <= dcd_pkg::RESET_BYTE;
         control_c_q <= dcd_pkg::RESET_BYTE;
      end else begin
         if (wr_a) control_a_q <= wbyte & dcd_pkg::CA_MASK; // RULE19
         if (wr_b) control_b_q <= wbyte & dcd_pkg::CB_MASK; // RULE19
         if (wr_c) control_c_q <= wbyte & dcd_pkg::CC_MASK; // RULE19
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trigger_sel_q <= dcd_pkg::RESET_BYTE;
         gain_q        <= dcd_pkg::RESET_BYTE;
         offset_q      <= dcd_pkg::RESET_BYTE;
      end else begin
         if (wr_ts)     trigger_sel_q <= wbyte & dcd_pkg::TS_MASK; // RULE19
         if (wr_gain)   gain_q        <= wbyte; // RULE17
         if (wr_offset) offset_q      <= wbyte; // RULE18
      end
   end

   // temporary low byte shared by both channels, as in the data byte pair
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         temp_q <= dcd_pkg::RESET_BYTE;
      end else if (|wr_low) begin
         temp_q <= align_high ? {wbyte[7:4], 4'h0} : wbyte; // RULE21 RULE22
      end
   end

   // read data mux, registered at the address phase
   wire  [7:0]           low_view   [2];
   wire  [7:0]           high_view  [2];
   logic [7:0]           rd_byte;
   assign low_view[0]  = align_high ? {pend_val_q[0][3:0], 4'h0} : pend_val_q[0][7:0];
   assign low_view[1]  = align_high ? {pend_val_q[1][3:0], 4'h0} : pend_val_q[1][7:0];
   assign high_view[0] = align_high ? pend_val_q[0][11:4] : {4'h0, pend_val_q[0][11:8]};
   assign high_view[1] = align_high ? pend_val_q[1][11:4] : {4'h0, pend_val_q[1][11:8]};

   always_comb begin
      rd_byte = 8'h00;
      if (a_in_range) begin
         unique case (a_idx)
            dcd_pkg::IDX_CONTROL_A:     rd_byte = control_a_q;
            dcd_pkg::IDX_CONTROL_B:     rd_byte = control_b_q;
            dcd_pkg::IDX_CONTROL_C:     rd_byte = control_c_q;
            dcd_pkg::IDX_TRIGGER_SEL:   rd_byte = trigger_sel_q;
            dcd_pkg::IDX_EMPTY_FLAGS:   rd_byte = {6'h00, empty_q}; // RULE14
            dcd_pkg::IDX_CH0_GAIN:      rd_byte = gain_q; // RULE17
            dcd_pkg::IDX_CH0_OFFSET:    rd_byte = offset_q; // RULE18
            dcd_pkg::IDX_CH0_DATA_LOW:  rd_byte = low_view[0];
            dcd_pkg::IDX_CH0_DATA_HIGH: rd_byte = high_view[0];
            dcd_pkg::IDX_CH1_DATA_LOW:  rd_byte = low_view[1];
            dcd_pkg::IDX_CH1_DATA_HIGH: rd_byte = high_view[1];
            default:                    rd_byte = 8'h00;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= 32'h0000_0000;
      end else if (addr_phase && !hwrite) begin
         hrdata_q <= {24'h00_0000, rd_byte};
      end
   end

   assign hrdata    = hrdata_q;
   assign hreadyout = 1'b1;
   assign hresp     = dcd_pkg::HRESP_OKAY;

   // requests and analog controls
   assign dma_request = empty_q; // RULE16

   assign chan0_analog.power_on   = chan_active[0] && (!low_power_select || !idle[0]); // RULE4
   assign chan0_analog.pin_drive  = enable && chan0_pin_enable && !internal_route_enable; // RULE1 RULE3
   assign chan0_analog.converting = !idle[0];
   assign chan0_analog.value      = out_val_q[0];
   assign chan1_analog.power_on   = chan_active[1] && (!low_power_select || !idle[1]); // RULE4
   assign chan1_analog.pin_drive  = enable && chan1_pin_enable; // RULE2
   assign chan1_analog.converting = !idle[1];
   assign chan1_analog.value      = out_val_q[1];

   assign trim.ch0_gain       = gain_q; // RULE17
   assign trim.ch0_offset     = offset_q; // RULE18
   assign trim.reference      = dcd_pkg::dcd_ref_t'(reference_select); // RULE10
   assign trim.internal_route = enable && internal_route_enable; // RULE1

endmodule

/* hdl/dcd_pkg.sv */
package dcd_pkg;

   // register indices; byte address is four times the index
   localparam logic [4:0] IDX_CONTROL_A     = 5'h00;
   localparam logic [4:0] IDX_CONTROL_B     = 5'h01;
   localparam logic [4:0] IDX_CONTROL_C     = 5'h02;
   localparam logic [4:0] IDX_TRIGGER_SEL   = 5'h03;
   localparam logic [4:0] IDX_EMPTY_FLAGS   = 5'h05;
   localparam logic [4:0] IDX_CH0_GAIN      = 5'h08;
   localparam logic [4:0] IDX_CH0_OFFSET    = 5'h09;
   localparam logic [4:0] IDX_CH0_DATA_LOW  = 5'h18;
   localparam logic [4:0] IDX_CH0_DATA_HIGH = 5'h19;
   localparam logic [4:0] IDX_CH1_DATA_LOW  = 5'h1A;
   localparam logic [4:0] IDX_CH1_DATA_HIGH = 5'h1B;

   localparam int IDX_LSB  = 2;
   localparam int IDX_MSB  = 6;
   localparam int ADDR_TOP = 31;

   // control a fields
   localparam int CA_ENABLE         = 0;
   localparam int CA_LOW_POWER      = 1;
   localparam int CA_CH0_PIN        = 2;
   localparam int CA_CH1_PIN        = 3;
   localparam int CA_INTERNAL_ROUTE = 4;
   localparam logic [7:0] CA_MASK   = 8'h1F;
   // control b fields
   localparam int CB_CH0_EVENT      = 0;
   localparam int CB_CH1_EVENT      = 1;
   localparam int CB_CHANNEL_COUNT_SELECT_LSB      = 5;
   localparam logic [7:0] CB_MASK   = 8'h63;
   // control c fields
   localparam int CC_ALIGN_HIGH     = 0;
   localparam int CC_REF_LSB        = 3;
   localparam logic [7:0] CC_MASK   = 8'h19;
   // trigger select fields
   localparam int TS_SPLIT          = 3;
   localparam logic [7:0] TS_MASK   = 8'h0F;
   localparam logic [7:0] RESET_BYTE = 8'h00;

   typedef enum logic [1:0] {
      DCD_CHANNEL_COUNT_SELECT_SINGLE0 = 2'b00,
      DCD_CHANNEL_COUNT_SELECT_ONE_CHANNEL_SECOND = 2'b01,
      DCD_CHANNEL_COUNT_SELECT_DUAL    = 2'b10,
      DCD_CHANNEL_COUNT_SELECT_RSVD    = 2'b11
   } dcd_channel_count_select_t;

   typedef enum logic [1:0] {
      DCD_REF_INT_1V   = 2'b00,
      DCD_REF_SUPPLY   = 2'b01,
      DCD_REF_PORT_A   = 2'b10,
      DCD_REF_PORT_D   = 2'b11
   } dcd_ref_t;

   typedef enum logic [1:0] {
      DCD_ST_IDLE = 2'b01,
      DCD_ST_CONV = 2'b10
   } dcd_state_t;

   // conversion timing at 20 MHz
   localparam int CLK_PERIOD_NS  = 50;
   localparam int CONV_TIME_NS   = 1000;
   localparam int CONV_CYCLES    = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LP_FACTOR      = 2;
   localparam int CNT_W          = 7;
   localparam logic [CNT_W-1:0] CONV_CNT    = CNT_W'(CONV_CYCLES);
   localparam logic [CNT_W-1:0] CONV_CNT_LP = CNT_W'(CONV_CYCLES * LP_FACTOR);
   localparam logic [CNT_W-1:0] CNT_ONE     = 7'h01;

   localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'b10;
   localparam logic       HRESP_OKAY        = 1'b0;

   // per-channel analog stage controls
   typedef struct packed {
      logic        power_on;
      logic        pin_drive;
      logic        converting;
      logic [11:0] value;
   } dcd_analog_t;

   // calibration and reference settings handed to the analog stage
   typedef struct packed {
      logic [7:0] ch0_gain;
      logic [7:0] ch0_offset;
      dcd_ref_t   reference;
      logic       internal_route;
   } dcd_trim_t;

endpackage

/* verif/dcd_event_source.sv */
`timescale 1ns/100ps
module dcd_event_source (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       fire,
   input  wire logic [2:0] fire_chan,
   output logic      [7:0] event_in
);
   // one event pulse of one cycle on the chosen channel, all channels quiet otherwise
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         event_in <= 8'h00;
      end else begin
         event_in <= fire ? (8'h01 << fire_chan) : 8'h00;
      end
   end
endmodule

/* verif/dcd_monitor.sv */
`timescale 1ns/100ps
module dcd_monitor (
   input wire logic                 hclk,
   input wire logic                 hresetn,
   input wire logic                 hsel,
   input wire logic [31:0]          haddr,
   input wire logic [1:0]           htrans,
   input wire logic                 hwrite,
   input wire logic [2:0]           hsize,
   input wire logic [31:0]          hwdata,
   input wire logic                 hready,
   input wire logic [31:0]          hrdata,
   input wire logic                 hreadyout,
   input wire logic                 hresp,
   input wire logic [7:0]           event_in,
   input wire logic [1:0]           dma_request,
   input wire dcd_pkg::dcd_analog_t chan0_analog,
   input wire dcd_pkg::dcd_analog_t chan1_analog,
   input wire dcd_pkg::dcd_trim_t   trim
);
   localparam int CONV = dcd_pkg::CONV_CYCLES;
   logic       wr_q;
   logic       rd_q;
   logic [5:0] c0_q;
   logic [5:0] c1_q;
   wire        take = hsel & hready & htrans[1];
   // data-phase markers and converting-cycle counters
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         c0_q <= 6'h00;
         c1_q <= 6'h00;
      end else begin
         wr_q <= take & hwrite;
         rd_q <= take & ~hwrite;
         c0_q <= chan0_analog.converting ? c0_q + 6'h01 : 6'h00;
         c1_q <= chan1_analog.converting ? c1_q + 6'h01 : 6'h00;
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   route_pin_a: assert property (trim.internal_route |-> !chan0_analog.pin_drive)
      else $error("channel 0 pin driven while routed inside");
   conv_power_a: assert property (chan0_analog.converting |-> chan0_analog.power_on)
      else $error("converting while powered down");
   conv0_len_a: assert property ($fell(chan0_analog.converting) |->
      c0_q == (chan0_analog.power_on ? CONV : 2 * CONV)) else $error("channel 0 conversion length wrong");
   conv1_len_a: assert property ($fell(chan1_analog.converting) |->
      c1_q == (chan1_analog.power_on ? CONV : 2 * CONV)) else $error("channel 1 conversion length wrong");
   value_start_a: assert property ($changed(chan0_analog.value) |-> chan0_analog.converting)
      else $error("value changed without a start");
   flag_clear_a: assert property ($fell(dma_request[0]) |-> $past(wr_q))
      else $error("channel 0 request dropped without a write");
   flag_set_a: assert property ($rose(dma_request[0]) |-> chan0_analog.converting || $past(wr_q))
      else $error("channel 0 request raised without a start");
   read_zero_a: assert property (rd_q |-> hrdata[31:8] == 24'h000000)
      else $error("upper read data not zero");
   cover property ($fell(chan0_analog.converting) && !chan0_analog.power_on);
   cover property ($rose(chan1_analog.converting));
   cover property (trim.internal_route);
endmodule

bind dcd_dual_channel_dac_control dcd_monitor i_dcd_monitor (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .event_in(event_in), .dma_request(dma_request), .chan0_analog(chan0_analog),
   .chan1_analog(chan1_analog), .trim(trim)
);

/* verif/dual_channel_dac_control_test.sv */
`timescale 1ns/100ps
`define CHK(g, e) begin \
   total_checks++; \
   if ((g) !== (e)) begin \
      fail_count++; \
      $display("Error at %0t: got %0h expected %0h", $time, (g), (e)); \
   end \
end
module dual_channel_dac_control_test;
   localparam logic [4:0] RX [6] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h08, 5'h09};
   localparam logic [7:0] MK [6] = '{8'h1F, 8'h63, 8'h19, 8'h0F, 8'hFF, 8'hFF};
   localparam logic [7:0] PA [4] = '{8'h0D, 8'h1D, 8'h0C, 8'h05};
   localparam logic [2:0] PE [4] = '{3'b110, 3'b011, 3'b000, 3'b100};
   logic                 hclk;
   logic                 hresetn;
   logic                 hsel;
   logic [31:0]          haddr;
   logic [1:0]           htrans;
   logic                 hwrite;
   logic [31:0]          hwdata;
   logic [31:0]          hrdata;
   logic                 hreadyout;
   logic                 hresp;
   logic [7:0]           event_in;
   logic [1:0]           dma_request;
   logic                 fire;
   logic [2:0]           fire_chan;
   dcd_pkg::dcd_analog_t a0;
   dcd_pkg::dcd_analog_t a1;
   dcd_pkg::dcd_trim_t   trim;
   logic [11:0]          e0;
   logic [11:0]          e1;
   logic [11:0]          v;
   logic                 sp;
   int                   fail_count;
   int                   total_checks;

   dcd_dual_channel_dac_control i_dcd_dual_channel_dac_control (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .event_in(event_in), .dma_request(dma_request), .chan0_analog(a0),
      .chan1_analog(a1), .trim(trim)
   );
   dcd_event_source i_dcd_event_source (
      .hclk(hclk), .hresetn(hresetn), .fire(fire), .fire_chan(fire_chan), .event_in(event_in)
   );

   task automatic bus(input logic [4:0] idx, input logic w, input logic [7:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr  <= {25'h0, idx, 2'b00};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= {24'h0, wd};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [4:0] idx, input logic [7:0] d);
      logic [31:0] x;
      bus(idx, 1'b1, d, x);
   endtask
   task automatic rd(input logic [4:0] idx, input logic [7:0] e);
      logic [31:0] x;
      bus(idx, 1'b0, 8'h00, x);
      `CHK(x, {24'h0, e})
   endtask
   // right-adjusted sample: low byte into the holding byte, high byte commits
   task automatic dat(input logic ch, input logic [11:0] d);
      wr(ch ? dcd_pkg::IDX_CH1_DATA_LOW : dcd_pkg::IDX_CH0_DATA_LOW, d[7:0]);
      wr(ch ? dcd_pkg::IDX_CH1_DATA_HIGH : dcd_pkg::IDX_CH0_DATA_HIGH, {4'h0, d[11:8]});
   endtask
   task automatic evt(input logic [2:0] c);
      @(posedge hclk);
      fire      <= 1'b1;
      fire_chan <= c;
      @(posedge hclk);
      fire <= 1'b0;
      repeat (3) @(negedge hclk);
   endtask
   task automatic conv_len(input int e);
      int n;
      n = 0;
      while (a0.converting !== 1'b1) @(negedge hclk);
      while (a0.converting === 1'b1) begin
         @(negedge hclk);
         n++;
      end
      `CHK(n, e)
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   initial begin
      repeat (40000) @(posedge hclk);
      fail_count++;
      finish_test();
   end
   initial begin
      fail_count = 0;
      total_checks = 0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hwdata = 32'h0;
      fire = 1'b0;
      fire_chan = 3'h0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rd(dcd_pkg::IDX_EMPTY_FLAGS, 8'h00);
      for (int i = 0; i < 6; i++) begin
         rd(RX[i], 8'h00);
         wr(RX[i], 8'hFF);
         rd(RX[i], MK[i]);
         wr(RX[i], 8'h00);
      end
      wr(5'h04, 8'hFF);
      rd(5'h04, 8'h00);
      wr(dcd_pkg::IDX_CH0_GAIN, 8'hA5);
      wr(dcd_pkg::IDX_CH0_OFFSET, 8'h5A);
      for (int r = 0; r < 4; r++) begin
         wr(dcd_pkg::IDX_CONTROL_C, 8'(r << 3));
         @(negedge hclk);
         `CHK(trim, {8'hA5, 8'h5A, 2'(r), 1'b0})
      end
      $display("end registers");
      for (int k = 0; k < 4; k++) begin
         wr(dcd_pkg::IDX_CONTROL_A, PA[k]);
         @(negedge hclk);
         `CHK({a0.pin_drive, a1.pin_drive, trim.internal_route}, PE[k])
      end
      $display("end pins");
      wr(dcd_pkg::IDX_CONTROL_A, 8'h01);
      dat(1'b0, 12'h234);
      conv_len(dcd_pkg::CONV_CYCLES);
      `CHK({a0.value, dma_request}, {12'h234, 2'b01})
      rd(dcd_pkg::IDX_EMPTY_FLAGS, 8'h01);
      wr(5'h05, 8'h02);
      rd(5'h05, 8'h02);
      wr(dcd_pkg::IDX_CONTROL_A, 8'h03);
      wr(dcd_pkg::IDX_CH0_DATA_HIGH, 8'h05);
      conv_len(2 * dcd_pkg::CONV_CYCLES);
      `CHK({a0.value, a0.power_on}, {12'h534, 1'b0})
      $display("end conversion");
      wr(dcd_pkg::IDX_CONTROL_A, 8'h01);
      wr(dcd_pkg::IDX_CONTROL_C, 8'h01);
      wr(dcd_pkg::IDX_CH0_DATA_LOW, 8'h00);
      wr(dcd_pkg::IDX_CH0_DATA_HIGH, 8'hC3);
      conv_len(dcd_pkg::CONV_CYCLES);
      `CHK(a0.value, 12'hC30)
      wr(dcd_pkg::IDX_CH0_DATA_LOW, 8'hF0);
      wr(dcd_pkg::IDX_CH0_DATA_HIGH, 8'h12);
      conv_len(dcd_pkg::CONV_CYCLES);
      `CHK(a0.value, 12'h12F)
      wr(dcd_pkg::IDX_CONTROL_C, 8'h00);
      $display("end alignment");
      e0 = 12'h12F;
      e1 = 12'h000;
      for (int c = 0; c < 4; c++) begin
         wr(dcd_pkg::IDX_CONTROL_B, 8'h63);
         dat(1'b0, 12'h300 + 12'(c));
         dat(1'b1, 12'h400 + 12'(c));
         wr(dcd_pkg::IDX_CONTROL_B, 8'(c << 5));
         repeat (45) @(negedge hclk);
         if (c == 0 || c == 2) e0 = 12'h300 + 12'(c);
         if (c == 1 || c == 2) e1 = 12'h400 + 12'(c);
         `CHK({a0.value, a1.value}, {e0, e1})
      end
      $display("end channel select");
      wr(dcd_pkg::IDX_CONTROL_B, 8'h43);
      for (int s = 0; s < 8; s++) begin
         sp = s[0];
         v  = 12'h500 + 12'(s);
         wr(dcd_pkg::IDX_TRIGGER_SEL, {4'h0, sp, 3'(s)});
         dat(1'b0, ~v);
         dat(1'b0, v);
         dat(1'b1, v + 12'h100);
         @(negedge hclk);
         `CHK(dma_request, 2'b00)
         evt(3'(s + 1));
         if (sp) e1 = v + 12'h100;
         `CHK({a0.value, a1.value, dma_request}, {e0, e1, sp, 1'b0})
         evt(3'(s));
         e0 = v;
         e1 = v + 12'h100;
         `CHK({a0.value, a1.value, dma_request}, {e0, e1, 2'b11})
         repeat (45) @(negedge hclk);
      end
      evt(3'h7);
      `CHK({a0.converting, a1.converting, hresp}, 3'b000)
      $display("end events");
      finish_test();
   end
endmodule
